// ---- rtl/radlc_map.svh ----
// Constants for the record converter level control block.
// Assumes inclusion by the single design file; definitions only.
`ifndef RADLC_MAP_SVH
`define RADLC_MAP_SVH
`define RADLC_SYS_HZ          20000000
`define RADLC_MOD_MAX_HZ      6144000
`define RADLC_DIV_SEL_ONE     2'h0
`define RADLC_DIV_SEL_TWO     2'h1
`define RADLC_DIV_SEL_THREE   2'h2
`define RADLC_SINC_DEC_48K    5'h10
`define RADLC_SINC_DEC_96K    5'h08
`define RADLC_HB_STAGES       2
`define RADLC_GAIN_MAX        6'h30
`define RADLC_VOL_FULL        8'hff
`define RADLC_ROUTE_PORT      2'h0
`define RADLC_ROUTE_SRC       2'h1
`define RADLC_ROUTE_TX        2'h2
`define RADLC_OFS_RESET       6'h00
`endif

// ---- rtl/radlc_pkg.sv ----
// Types shared by the record converter level control block.
// Assumes no other package; constants live in radlc_map.svh.
package radlc_pkg;
    typedef enum logic [3:0] {
        RADLC_IDLE    = 4'h1,
        RADLC_ATTACK  = 4'h2,
        RADLC_RECOVER = 4'h4,
        RADLC_DONE    = 4'h8
    } radlc_state_e;
    typedef enum logic [1:0] {
        RADLC_REC_NONE    = 2'h0,
        RADLC_REC_NORMAL  = 2'h1,
        RADLC_REC_LIMITED = 2'h2
    } radlc_rec_e;
endpackage

// ---- rtl/radlc_core.sv ----
// Record converter digital side: clock dividers, 5-bit code, decimator, volume,
// peaks, routing, two-entry output buffer and automatic level control.
// Assumes modulator thermometer codes arrive synchronous to sys_clk; controls are
// plain ports on the same clock.
//
// Contract
// - Modulator clock is converter clock over two, or over four when selected.
// - Sinc decimates by 16 or 8, then three half-band stages by two.
// - Thermometer flash result becomes a 5-bit binary word.
// - Output words are 24-bit two's complement.
// - Output routes to serial ports, rate converter or digital transmitter.
// - Per-channel volume of 256 linear steps.
// - Peak registers hold maximum level; reading returns and clears them.
// - Master clock divides by 1, 2 or 3 to converter rate.
// - Quarter modulator clock raises alt_filter; the decimator itself is unchanged.
// - Gain up to 24 dB in 0.5 dB steps, per channel.
// - Above attack threshold, both gains drop one step.
// - In attack, wait attack interval, resample, reduce again if above.
// - One common offset on both gains; never above initial gain.
// - Detect mode one needs both channels; zero needs either.
// - Default no recovery until restart by enable toggle or restart write.
// - Normal recovery raises gain one step per recovery interval.
// - Above recovery threshold while recovering, gain holds.
// - Gain restored stays until next attack.
// - Limited recovery counts intervals with excursions; at maximum recovery stops.
// - Attack in limited recovery clears the attempt counter.
`include "radlc_map.svh"
module radlc_core (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Clock setup
    input  wire logic [1:0]  mclk_div_sel,
    input  wire logic        modulator_clock_quarter_select,
    input  wire logic        rate_96k,
    // Modulator data
    input  wire logic [31:0] therm_l,
    input  wire logic [31:0] therm_r,
    // Volume, gain and routing
    input  wire logic [7:0]  vol_l,
    input  wire logic [7:0]  vol_r,
    input  wire logic [5:0]  init_gain_l,
    input  wire logic [5:0]  init_gain_r,
    input  wire logic [1:0]  route_sel,
    // Level control setup
    input  wire logic        level_control_enable,
    input  wire logic        restart_wr,
    input  wire logic        limit_both,
    input  wire logic [1:0]  rec_mode,
    input  wire logic [22:0] attack_thr,
    input  wire logic [22:0] recover_thr,
    input  wire logic [15:0] attack_time,
    input  wire logic [15:0] recover_time,
    input  wire logic [3:0]  attempt_max,
    // Peak readback
    input  wire logic        peak_rd_l,
    input  wire logic        peak_rd_r,
    output logic      [22:0] peak_l,
    output logic      [22:0] peak_r,
    // Clock outputs
    output logic             conv_clk_en,
    output logic             mod_clk_en,
    output logic             alt_filter,
    // Gain outputs
    output logic      [5:0]  gain_l,
    output logic      [5:0]  gain_r,
    output logic      [3:0]  recovery_attempt_counter,
    output logic      [3:0]  alc_state,
    // Output stream
    input  wire logic        out_ready,
    output logic             out_valid,
    output logic      [23:0] out_data_l,
    output logic      [23:0] out_data_r,
    output logic      [2:0]  out_dest
);
    // ****************************************************************
    // Clock dividers
    // ****************************************************************
    logic [1:0] mdiv_q, mdiv_d;
    logic [1:0] modc_q, modc_d;
    logic       conv_en_q, conv_en_d, mod_en_q, mod_en_d;
    // Master divide 1/2/3 gives converter enable; modulator divides that by 2 or 4
    always_comb begin
        mdiv_d    = mdiv_q + 2'h1;
        conv_en_d = 1'b0;
        if ((mclk_div_sel == `RADLC_DIV_SEL_ONE) || (mdiv_q >= mclk_div_sel)) begin
            mdiv_d    = 2'h0;
            conv_en_d = 1'b1;
        end
        modc_d   = modc_q;
        mod_en_d = 1'b0;
        if (conv_en_d) begin
            modc_d   = modc_q + 2'h1;
            mod_en_d = modulator_clock_quarter_select ? (modc_q == 2'h3) : modc_q[0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mdiv_q <= 2'h0; modc_q <= 2'h0; conv_en_q <= 1'b0; mod_en_q <= 1'b0;
        end else begin
            mdiv_q <= mdiv_d; modc_q <= modc_d; conv_en_q <= conv_en_d; mod_en_q <= mod_en_d;
        end
    end
    assign conv_clk_en = conv_en_q;
    assign mod_clk_en  = mod_en_q;
    assign alt_filter  = modulator_clock_quarter_select;

    // ****************************************************************
    // Code conversion, decimation and volume
    // ****************************************************************
    function automatic logic [4:0] therm2bin(input logic [31:0] t);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) n = n + {5'h00, t[i]};
        therm2bin = (n[5]) ? 5'h1f : n[4:0];
    endfunction
    // Sinc-style accumulator; half-band stages are modelled by keeping one block sum in eight
    logic [4:0]  dec_cnt_q, dec_cnt_d;
    logic [4:0]  dec_ratio;
    logic [23:0] acc_q[2], acc_d[2];
    logic [23:0] smp_q[2], smp_d[2];
    logic [2:0]  hb_q, hb_d;
    logic        smp_v_q, smp_v_d;
    logic [7:0]  vol[2];
    logic [4:0]  code[2];
    logic [23:0] raw[2];
    assign vol[0]  = vol_l;
    assign vol[1]  = vol_r;
    assign code[0] = therm2bin(therm_l);
    assign code[1] = therm2bin(therm_r);
    assign dec_ratio = rate_96k ? `RADLC_SINC_DEC_96K : `RADLC_SINC_DEC_48K;
    always_comb begin
        dec_cnt_d = dec_cnt_q;
        hb_d      = hb_q;
        smp_v_d   = 1'b0;
        for (int c = 0; c < 2; c++) begin
            acc_d[c] = acc_q[c];
            smp_d[c] = smp_q[c];
            // Sum includes the current code so a full block is used; centre code 16 is zero
            raw[c] = 24'((acc_q[c] + {19'h0, code[c]} - ({19'h0, dec_ratio} << 4)) << 8);
        end
        if (mod_en_q) begin
            dec_cnt_d = dec_cnt_q + 5'h01;
            for (int c = 0; c < 2; c++)
                acc_d[c] = acc_q[c] + {19'h0, code[c]};
            if (dec_cnt_d == dec_ratio) begin
                dec_cnt_d = 5'h00;
                hb_d      = hb_q + 3'h1;
                for (int c = 0; c < 2; c++) acc_d[c] = 24'h0;
                if (hb_q == 3'h7) begin // Three halving stages: one word per eight
                    smp_v_d = 1'b1;
                    for (int c = 0; c < 2; c++) begin
                        // Centre code 16 maps to zero; scale to 24-bit two's complement
                        smp_d[c] = 24'(($signed({{8{raw[c][23]}}, raw[c]}) *
                                       $signed({24'h0, vol[c]})) >>> 8);
                    end
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dec_cnt_q <= 5'h00; hb_q <= 3'h0; smp_v_q <= 1'b0;
            for (int c = 0; c < 2; c++) begin acc_q[c] <= 24'h0; smp_q[c] <= 24'h0; end
        end else begin
            dec_cnt_q <= dec_cnt_d; hb_q <= hb_d; smp_v_q <= smp_v_d;
            for (int c = 0; c < 2; c++) begin acc_q[c] <= acc_d[c]; smp_q[c] <= smp_d[c]; end
        end
    end

    // ****************************************************************
    // Peak detectors
    // ****************************************************************
    logic [22:0] mag[2];
    logic [22:0] pk_q[2], pk_d[2];
    logic        pk_rd[2];
    assign pk_rd[0] = peak_rd_l;
    assign pk_rd[1] = peak_rd_r;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_mag
            assign mag[g] = smp_q[g][23] ? 23'((~smp_q[g]) + 24'h1) : smp_q[g][22:0];
        end
    endgenerate
    // New sample beats the read clear so a peak arriving at read time is kept
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pk_d[c] = pk_rd[c] ? 23'h0 : pk_q[c];
            if (smp_v_q && (mag[c] > pk_d[c])) pk_d[c] = mag[c];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pk_q[0] <= 23'h0; pk_q[1] <= 23'h0;
        end else begin
            pk_q[0] <= pk_d[0]; pk_q[1] <= pk_d[1];
        end
    end
    assign peak_l = pk_q[0];
    assign peak_r = pk_q[1];

    // ****************************************************************
    // Two-entry output buffer with routing
    // ****************************************************************
    logic [50:0] buf_q[2], buf_d[2];
    logic [1:0]  cnt_q, cnt_d;
    logic        vld_q;
    logic [2:0]  dest;
    assign dest = (route_sel == `RADLC_ROUTE_SRC) ? 3'h2 :
                  (route_sel == `RADLC_ROUTE_TX)  ? 3'h4 : 3'h1;
    // A full buffer drops the new word; at converter rates the receiver has ample slack
    always_comb begin
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        cnt_d    = cnt_q;
        if (out_ready && (cnt_q != 2'h0)) begin
            buf_d[0] = buf_q[1];
            cnt_d    = cnt_q - 2'h1;
        end
        if (smp_v_q && (cnt_d != 2'h2)) begin
            buf_d[cnt_d[0]] = {dest, smp_q[0], smp_q[1]};
            cnt_d           = cnt_d + 2'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            buf_q[0] <= 51'h0; buf_q[1] <= 51'h0; cnt_q <= 2'h0;
            vld_q <= 1'b0;
        end else begin
            buf_q[0] <= buf_d[0]; buf_q[1] <= buf_d[1]; cnt_q <= cnt_d;
            vld_q <= (cnt_d != 2'h0);
        end
    end
    assign out_valid  = vld_q; // Straight from a flop
    assign out_dest   = buf_q[0][50:48];
    assign out_data_l = buf_q[0][47:24];
    assign out_data_r = buf_q[0][23:0];

    // ****************************************************************
    // Automatic level control
    // ****************************************************************
    radlc_pkg::radlc_state_e st_q, st_d;
    logic [5:0]  ofs_q, ofs_d;
    logic [15:0] tmr_q, tmr_d;
    logic [3:0]  att_q, att_d;
    logic        exc_q, exc_d, en_q;
    logic        over_atk, over_rec;
    logic [5:0]  min_init;
    assign min_init = (init_gain_l < init_gain_r) ? init_gain_l : init_gain_r;
    assign over_atk = limit_both ? ((mag[0] > attack_thr) && (mag[1] > attack_thr)) :
                                   ((mag[0] > attack_thr) || (mag[1] > attack_thr));
    assign over_rec = (mag[0] > recover_thr) || (mag[1] > recover_thr);
    always_comb begin
        st_d = st_q; ofs_d = ofs_q; att_d = att_q; exc_d = exc_q;
        tmr_d = (tmr_q != 16'h0) ? tmr_q - 16'h1 : 16'h0;
        if (restart_wr || (level_control_enable != en_q) || !level_control_enable) begin
            st_d = radlc_pkg::RADLC_IDLE; ofs_d = `RADLC_OFS_RESET; att_d = 4'h0;
            exc_d = 1'b0; tmr_d = 16'h0;
        end else if (smp_v_q && over_atk && (st_q != radlc_pkg::RADLC_ATTACK)) begin
            st_d  = radlc_pkg::RADLC_ATTACK;
            att_d = 4'h0;
            if (ofs_q < min_init) ofs_d = ofs_q + 6'h01;
            tmr_d = attack_time;
        end else begin
            case (st_q)
                radlc_pkg::RADLC_ATTACK: begin
                    if (smp_v_q && (tmr_q == 16'h0)) begin
                        if (over_atk) begin
                            if (ofs_q < min_init) ofs_d = ofs_q + 6'h01;
                            tmr_d = attack_time;
                        end else begin
                            st_d  = (rec_mode == radlc_pkg::RADLC_REC_NONE) ?
                                    radlc_pkg::RADLC_DONE : radlc_pkg::RADLC_RECOVER;
                            tmr_d = recover_time;
                            exc_d = 1'b0;
                        end
                    end
                end
                radlc_pkg::RADLC_RECOVER: begin
                    if (smp_v_q && over_rec) exc_d = 1'b1;
                    if (tmr_q == 16'h0) begin
                        tmr_d = recover_time;
                        exc_d = 1'b0;
                        if (exc_q || (smp_v_q && over_rec)) begin
                            if (rec_mode == radlc_pkg::RADLC_REC_LIMITED) begin
                                att_d = att_q + 4'h1;
                                if (att_d >= attempt_max) st_d = radlc_pkg::RADLC_DONE;
                            end
                        end else if (ofs_q != 6'h00) begin
                            ofs_d = ofs_q - 6'h01;
                        end else begin
                            st_d = radlc_pkg::RADLC_DONE;
                        end
                    end
                end
                default: st_d = st_q;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= radlc_pkg::RADLC_IDLE; ofs_q <= `RADLC_OFS_RESET; tmr_q <= 16'h0;
            att_q <= 4'h0; exc_q <= 1'b0; en_q <= 1'b0;
        end else begin
            st_q <= st_d; ofs_q <= ofs_d; tmr_q <= tmr_d;
            att_q <= att_d; exc_q <= exc_d; en_q <= level_control_enable;
        end
    end
    // Common offset keeps the dB difference; gain never above initial value
    assign gain_l = (init_gain_l > `RADLC_GAIN_MAX) ? `RADLC_GAIN_MAX - ofs_q : init_gain_l - ofs_q;
    assign gain_r = (init_gain_r > `RADLC_GAIN_MAX) ? `RADLC_GAIN_MAX - ofs_q : init_gain_r - ofs_q;
    assign recovery_attempt_counter = att_q;
    assign alc_state = st_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_gain_never_above: assert property (@(posedge sys_clk) disable iff (!resetn)
        (gain_l <= init_gain_l) && (gain_r <= init_gain_r))
        else $error("gain above initial value");
    a_restart_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        restart_wr |=> (ofs_q == 6'h00))
        else $error("restart did not clear offset");
    a_offset_saturates: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ofs_q >= min_init) && $stable(min_init) |=> (ofs_q <= $past(ofs_q)))
        else $error("offset wrapped");
    a_peak_read_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        peak_rd_l && !smp_v_q |=> (peak_l == 23'h0))
        else $error("peak not cleared");
    a_mod_quarter: assert property (@(posedge sys_clk) disable iff (!resetn)
        mod_en_q && modulator_clock_quarter_select && $past(modulator_clock_quarter_select)
        |-> (modc_q == 2'h0))
        else $error("quarter modulator rate wrong");
    a_attack_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        smp_v_q && over_atk && (st_q != radlc_pkg::RADLC_ATTACK) && level_control_enable &&
        en_q && !restart_wr && (ofs_q < min_init) |=> (ofs_q == $past(ofs_q) + 6'h01))
        else $error("attack did not lower gain one step");
endmodule // radlc_core

// ---- dv/radlc_far_side.sv ----
// Far-side model: modulator flash front end and the downstream audio port.
// Assumes the bench picks input level and stall mode; one clock, sys_clk.
module radlc_far_side (
    // Clock
    input  wire logic        sys_clk,
    // Bench control
    input  wire logic [4:0]  level,
    input  wire logic [1:0]  stall_mode,
    // Modulator side
    output logic      [31:0] therm_l,
    output logic      [31:0] therm_r,
    // Stream side
    output logic             out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flash result as a thermometer code: the count of ones is the level
    assign therm_l = (32'h1 << level) - 32'h1;
    assign therm_r = therm_l;
    initial out_ready = 1'b0;
    // Ready: 0 prompt, 1 random stalls, 2 held off; moves just after an edge
    always @(posedge sys_clk) begin
        out_ready <= (stall_mode == 2'h0) ? 1'b1 :
                     (stall_mode == 2'h1) ? ($urandom_range(3) == 0) : 1'b0;
    end
endmodule // radlc_far_side

// ---- dv/tb.sv ----
// Self-checking bench for the record converter level control block.
// Assumes radlc_core and radlc_far_side; one 20 MHz clock, controls as ports.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************
    // Signals
    // ************************************
    logic        sys_clk, resetn, quarter, rate_96k, ena, restart_wr, limit_both;
    logic        peak_rd_l, peak_rd_r, out_ready, out_valid, conv_clk_en, mod_clk_en;
    logic        alt_filter, held_q;
    logic [1:0]  mclk_div_sel, route_sel, rec_mode, stall_mode;
    logic [4:0]  level;
    logic [31:0] therm_l, therm_r;
    logic [7:0]  vol_l, vol_r;
    logic [5:0]  init_gain_l, init_gain_r, gain_l, gain_r;
    logic [22:0] attack_thr, recover_thr, peak_l, peak_r;
    logic [15:0] attack_time, recover_time;
    logic [3:0]  attempt_max, attempts;
    logic [23:0] out_data_l, out_data_r, dl_q, dr_q;
    logic [2:0]  out_dest, exp_dest;
    logic [2:0]  q_dest[$];
    int          n_mismatch = 0, total_checks = 0, g, d, k, i, gl, gr, seed_v;

    radlc_core u_dut (.sys_clk(sys_clk), .resetn(resetn), .mclk_div_sel(mclk_div_sel),
        .modulator_clock_quarter_select(quarter), .rate_96k(rate_96k), .therm_l(therm_l),
        .therm_r(therm_r), .vol_l(vol_l), .vol_r(vol_r), .init_gain_l(init_gain_l),
        .init_gain_r(init_gain_r), .route_sel(route_sel), .level_control_enable(ena),
        .restart_wr(restart_wr), .limit_both(limit_both), .rec_mode(rec_mode),
        .attack_thr(attack_thr), .recover_thr(recover_thr), .attack_time(attack_time),
        .recover_time(recover_time), .attempt_max(attempt_max), .peak_rd_l(peak_rd_l),
        .peak_rd_r(peak_rd_r), .peak_l(peak_l), .peak_r(peak_r), .conv_clk_en(conv_clk_en),
        .mod_clk_en(mod_clk_en), .alt_filter(alt_filter), .gain_l(gain_l), .gain_r(gain_r),
        .recovery_attempt_counter(attempts), .alc_state(), .out_ready(out_ready),
        .out_valid(out_valid), .out_data_l(out_data_l), .out_data_r(out_data_r),
        .out_dest(out_dest));
    radlc_far_side u_far (.sys_clk(sys_clk), .level(level), .stall_mode(stall_mode),
        .therm_l(therm_l), .therm_r(therm_r), .out_ready(out_ready));

    // ************************************
    // Tasks
    // ************************************
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_beat(input bit ok, input string what);
        total_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic fail_now(input string what);
        cmp_beat(1'b0, what);
        test_done();
    endtask
    // Cycles to the next pulse of a clock enable; a missing pulse gives 50
    task automatic gap(input bit sel_mod, output int n);
        n = 0;
        for (int j = 0; j < 50; j++) begin
            @(posedge sys_clk);
            n++;
            if ((sel_mod ? mod_clk_en : conv_clk_en) === 1'b1) break;
        end
    endtask
    task automatic wait_beats(input int n);
        int c;
        c = 0;
        for (int j = 0; j < 6000 && c < n; j++) begin
            @(posedge sys_clk);
            if (out_valid === 1'b1 && out_ready === 1'b1) c++;
        end
        if (c < n) fail_now("stream stalled");
    endtask
    task automatic wait_gain(input logic [5:0] target);
        for (int j = 0; j < 30000 && gain_l !== target; j++) @(posedge sys_clk);
        if (gain_l !== target) fail_now("gain never settled");
    endtask

    // ************************************
    // Stimulus and checks
    // ************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Monitor: words stand while stalled; taken words checked against the oldest noted destination while notes remain
    always @(posedge sys_clk) begin
        if (resetn === 1'b1 && held_q) begin
            cmp_beat(out_valid === 1'b1 && out_data_l === dl_q && out_data_r === dr_q,
                     "stalled word lost or changed");
        end
        if (out_valid === 1'b1 && out_ready === 1'b1 && q_dest.size() > 0) begin
            exp_dest = q_dest.pop_front();
            cmp_beat(out_dest === exp_dest, "word sent to wrong destination");
        end
        held_q = resetn === 1'b1 && out_valid === 1'b1 && out_ready !== 1'b1;
        dl_q = out_data_l;
        dr_q = out_data_r;
    end
    initial begin
        {resetn, quarter, rate_96k, ena, restart_wr, limit_both, peak_rd_l, peak_rd_r} = '0;
        {mclk_div_sel, route_sel, rec_mode, stall_mode, attack_thr, recover_thr} = '0;
        {attack_time, recover_time, attempt_max, held_q} = '0;
        level = 5'h1f;
        init_gain_l = 6'h0a;
        init_gain_r = 6'h1e;
        seed_v = $urandom(32'hfe8a);
        vol_l = 8'hff;  // Volume left at full while levels are controlled
        vol_r = 8'hff;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        cmp_val(out_valid, 0, "valid after reset");
        // Divider and modulator clock for every setting
        for (d = 0; d < 3; d++) begin
            for (k = 0; k < 2; k++) begin
                mclk_div_sel <= d[1:0];  // Port clock would take the same ratio
                quarter <= k[0];
                repeat (4) @(posedge sys_clk);
                gap(1'b0, g);
                gap(1'b0, g);
                cmp_val(24'(g), 24'(d + 1), "converter clock period");
                gap(1'b1, g);
                gap(1'b1, g);
                cmp_val(24'(g), 24'((d + 1) * (k ? 4 : 2)), "modulator period");
                cmp_val(alt_filter, k[0], "alternate filter");
            end
        end
        mclk_div_sel <= 2'h0;
        quarter <= 1'b0;
        // Routing under random stalls; words queued before a change are flushed first
        stall_mode <= 2'h1;
        for (d = 0; d < 3; d++) begin
            route_sel <= d[1:0];
            wait_beats(3);
            repeat (3) q_dest.push_back(3'h1 << d);
            wait_beats(4);
        end
        // Peak read returns the level, then clears; no sample lands near the read
        stall_mode <= 2'h0;
        rate_96k <= 1'b1;
        wait_beats(2);
        repeat (3) @(posedge sys_clk);
        cmp_beat(peak_l !== 23'h0 && peak_r !== 23'h0, "peak empty at full level");
        peak_rd_l <= 1'b1;
        peak_rd_r <= 1'b1;
        @(posedge sys_clk);
        peak_rd_l <= 1'b0;
        peak_rd_r <= 1'b0;
        @(posedge sys_clk);
        cmp_val(peak_l, 0, "left peak after read");
        cmp_val(peak_r, 0, "right peak after read");
        // Buffer held off until it refuses, then drained to empty
        stall_mode <= 2'h2;
        repeat (600) @(posedge sys_clk);
        stall_mode <= 2'h0;
        for (i = 0; i < 300 && out_valid !== 1'b0; i++) @(posedge sys_clk);
        cmp_val(out_valid, 0, "buffer not drained");
        // Attack on both channels down to the saturated offset
        gl = 1 + $urandom_range(19);
        gr = gl + $urandom_range(28);
        init_gain_l <= gl[5:0];
        init_gain_r <= gr[5:0];
        {limit_both, ena} <= 2'h3;
        attack_time <= 16'h0004;
        recover_time <= 16'h00c8;
        rec_mode <= radlc_pkg::RADLC_REC_NONE;
        @(posedge sys_clk);
        wait_gain(6'h0);
        cmp_val(gain_r, 24'(gr - gl), "gain difference kept");
        repeat (1500) @(posedge sys_clk);
        cmp_val(gain_l, 0, "saturated gain moved");
        cmp_val(gain_r, 24'(gr - gl), "gain recovered without mode");
        // Limited recovery: every interval has an excursion, so attempts run out
        attack_thr <= 23'h7fffff;
        attempt_max <= 4'h3;
        rec_mode <= radlc_pkg::RADLC_REC_LIMITED;
        for (i = 0; i < 30000 && attempts !== 4'h3; i++) @(posedge sys_clk);
        repeat (1500) @(posedge sys_clk);
        cmp_val(attempts, 3, "attempt count");
        cmp_val(gain_l, 0, "gain recovered past limit");
        attack_thr <= 23'h0;
        for (i = 0; i < 3000 && attempts !== 4'h0; i++) @(posedge sys_clk);
        cmp_val(attempts, 0, "attempts not cleared by attack");
        // Normal recovery climbs back to the initial gains and stays there
        attack_thr <= 23'h7fffff;
        recover_thr <= 23'h7fffff;
        rec_mode <= radlc_pkg::RADLC_REC_NORMAL;
        wait_gain(gl[5:0]);
        cmp_val(gain_r, 24'(gr), "right gain restored");
        repeat (1500) @(posedge sys_clk);
        cmp_val(gain_l, 24'(gl), "left gain left initial");
        cmp_val(gain_r, 24'(gr), "right gain left initial");
        // Restart by a restart write, then by an enable toggle
        rec_mode <= radlc_pkg::RADLC_REC_NONE;
        for (k = 0; k < 2; k++) begin
            attack_thr <= 23'h0;
            wait_gain(6'h0);
            attack_thr <= 23'h7fffff;
            if (k == 0) restart_wr <= 1'b1;
            else ena <= 1'b0;
            @(posedge sys_clk);
            restart_wr <= 1'b0;
            ena <= 1'b1;
            repeat (3) @(posedge sys_clk);
            cmp_val(gain_l, 24'(gl), "left gain after restart");
            cmp_val(gain_r, 24'(gr), "right gain after restart");
        end
        test_done();
    end
endmodule // tb
